// >>> design/hgt_map.svh
// Register offsets, field positions, reset values and timing counts of the timer block.
`ifndef HGT_MAP_SVH
`define HGT_MAP_SVH
`define HGT_OFS_CONFIG      8'h8C
`define HGT_OFS_COUNT       8'h90
`define HGT_OFS_FREE_RUN    8'h9C
`define HGT_BIT_RUN_EN      29
`define HGT_PRELOAD_RST     16'hFFFF
`define HGT_COUNT_RST       16'hFFFF
`define HGT_CLK_MHZ         125
`define HGT_REF_MHZ         25
`define HGT_REF_DIV         (`HGT_CLK_MHZ / `HGT_REF_MHZ)
`define HGT_GPT_TICK_NS     1000
`define HGT_GPT_TICK_CYC    ((`HGT_GPT_TICK_NS * `HGT_CLK_MHZ) / 1000)
`define HGT_CLEAR_NS        160
`define HGT_CLEAR_CYC       ((`HGT_CLEAR_NS * `HGT_CLK_MHZ) / 1000)
`endif

// >>> design/hgt_pkg.sv
// Types shared by the timer block.
package hgt_pkg;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } hgt_bus_req_type;
   typedef enum logic {HGT_HALTED, HGT_RUNNING} hgt_run_type;
endpackage

// >>> design/hgt_timer.sv
// General purpose down timer and free-running reference counter behind a 16-bit register port.
`include "hgt_map.svh"
// What this block does
// R1 - Writing one to the run bit starts the general timer counting.
// R2 - Clearing the run bit halts the general timer count.
// R3 - Each one-to-zero change of the run bit forces preload to FFFFh.
// R4 - Host-writable 16-bit preload in config low field, resets FFFFh, loads timer.
// R5 - The general timer raises host interrupts at the programmed interval.
// R6 - Live timer value is read-only 16-bit count, resets FFFFh, upper bits zero.
// R7 - A 32-bit free-running counter starts from zero after reset release.
// R8 - The free-running counter advances once per 25MHz reference cycle.
// R9 - After all ones the free-running counter wraps to zero and continues.
// R10 - The first 16-bit read latches the whole 32-bit free-running count.
// R11 - Counter may take up to 160ns after reset to show zero.
// R12 - The free-running counter runs in every power state.
// R13 - Running timer counts down per tick, flags at zero, reloads preload.
// R14 - Reading the upper half returns the latched value without recapture.
module hgt_timer
   import hgt_pkg::*;
(
   input  wire logic            clk_sys_i,
   input  wire logic            rst_n_i,
   input  wire hgt_bus_req_type bus_i,
   input  wire logic            bus_hi_i,
   input  wire logic            irq_clr_i,
   output logic [15:0]          rdata_o,
   output logic                 irq_o,
   output logic                 clear_done_o
);
   // Register state and next values.
   logic [15:0] preload_r;
   logic [15:0] preload_nxt;
   hgt_run_type run_r;
   hgt_run_type run_nxt;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [9:0]  tick_r;
   logic [9:0]  tick_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic [2:0]  ref_r;
   logic [2:0]  ref_nxt;
   logic [31:0] free_r;
   logic [31:0] free_nxt;
   logic [31:0] latch_r;
   logic [31:0] latch_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [7:0]  clr_r;
   logic [7:0]  clr_nxt;
   logic        clr_done_r;
   logic        clr_done_nxt;

   // Register port decode.
   wire        sel_cfg    = bus_i.addr == `HGT_OFS_CONFIG;
   wire        sel_cnt    = bus_i.addr == `HGT_OFS_COUNT;
   wire        sel_free   = bus_i.addr == `HGT_OFS_FREE_RUN;
   wire        wr_cfg     = bus_i.wr && sel_cfg;
   wire        wr_cfg_lo  = wr_cfg && !bus_hi_i;
   wire        wr_cfg_hi  = wr_cfg && bus_hi_i;
   wire        rd_any     = bus_i.rd;
   wire        free_first = rd_any && sel_free && !bus_hi_i;

   // Run control.
   wire        running    = run_r == HGT_RUNNING;
   wire        run_wdata  = bus_i.wdata[`HGT_BIT_RUN_EN - 16];
   wire        run_fall   = wr_cfg_hi && !run_wdata && running;

   // Timer tick, expiry and interrupt flag control; a set beats a clear in the same cycle.
   wire        tick       = tick_r == 10'(`HGT_GPT_TICK_CYC - 1);
   wire        step       = running && tick; // R1 R2
   wire        at_zero    = count_r == 16'h0000;
   wire [15:0] count_dec  = count_r - 16'h0001;
   wire        irq_set    = step && at_zero; // R13
   wire        irq_clear  = irq_clr_i && !irq_set;

   // Reference divider and reset clear window.
   wire        ref_step   = ref_r == 3'(`HGT_REF_DIV - 1);
   wire        clr_last   = clr_r == 8'(`HGT_CLEAR_CYC - 1);
   wire        clr_full   = clr_r == 8'(`HGT_CLEAR_CYC);

   // Read words of each register half.
   wire [15:0] cfg_lo_word  = preload_r; // R4
   wire [15:0] cfg_hi_word  = {2'h0, running, 13'h0000}; // R1 R2
   wire [15:0] cnt_lo_word  = count_r; // R6
   wire [15:0] cnt_hi_word  = 16'h0000; // R6
   wire [15:0] free_lo_word = free_r[15:0]; // R10
   wire [15:0] free_hi_word = latch_r[31:16]; // R14
   wire [15:0] cfg_word     = bus_hi_i ? cfg_hi_word : cfg_lo_word;
   wire [15:0] cnt_word     = bus_hi_i ? cnt_hi_word : cnt_lo_word;
   wire [15:0] free_word    = bus_hi_i ? free_hi_word : free_lo_word;
   wire [15:0] rd_mux       = sel_cfg  ? cfg_word  :
                              sel_cnt  ? cnt_word  :
                              sel_free ? free_word :
                              16'h0000;

   // Next values of the registers.
   assign preload_nxt  = run_fall ? `HGT_PRELOAD_RST : (wr_cfg_lo ? bus_i.wdata : preload_r); // R3 R4
   assign run_nxt      = wr_cfg_hi ? (run_wdata ? HGT_RUNNING : HGT_HALTED) : run_r; // R1 R2
   assign tick_nxt     = (tick || !running) ? 10'h000 : tick_r + 10'h001;
   assign irq_nxt      = irq_set ? 1'h1 : (irq_clear ? 1'h0 : irq_r); // R5
   assign ref_nxt      = ref_step ? 3'h0 : ref_r + 3'h1;
   assign free_nxt     = ref_step ? free_r + 32'h0000_0001 : free_r; // R8 R9 R12
   assign latch_nxt    = free_first ? free_r : latch_r; // R10
   assign rdata_nxt    = rd_any ? rd_mux : rdata_r;
   assign clr_nxt      = clr_full ? clr_r : clr_r + 8'h01; // R11
   assign clr_done_nxt = clr_done_r || clr_last; // R11

   always_comb
   begin
      count_nxt = count_r;
      if (wr_cfg_lo)
         count_nxt = bus_i.wdata; // R4
      else if (step)
         count_nxt = at_zero ? preload_r : count_dec; // R13
   end

   // Preload value of the timer.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         preload_r <= `HGT_PRELOAD_RST; // R4
      else
         preload_r <= preload_nxt;
   end

   // Run or halt state of the timer.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         run_r <= HGT_HALTED;
      else
         run_r <= run_nxt;
   end

   // Live timer count.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         count_r <= `HGT_COUNT_RST; // R6
      else
         count_r <= count_nxt;
   end

   // Divider that makes the timer tick.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tick_r <= 10'h000;
      else
         tick_r <= tick_nxt;
   end

   // Sticky timer interrupt flag.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_r <= 1'h0;
      else
         irq_r <= irq_nxt;
   end

   // Divider that makes the reference step.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ref_r <= 3'h0;
      else
         ref_r <= ref_nxt;
   end

   // Free-running reference count.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         free_r <= 32'h0000_0000; // R7
      else
         free_r <= free_nxt;
   end

   // Copy of the count taken by a low-half read.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         latch_r <= 32'h0000_0000;
      else
         latch_r <= latch_nxt;
   end

   // Read data, held until the next read.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_r <= 16'h0000;
      else
         rdata_r <= rdata_nxt;
   end

   // Cycles counted since reset was released.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         clr_r <= 8'h00;
      else
         clr_r <= clr_nxt;
   end

   // Flag that the clear window after reset is over.
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         clr_done_r <= 1'h0;
      else
         clr_done_r <= clr_done_nxt;
   end

   // Outputs straight from flip-flops.
   assign rdata_o      = rdata_r;
   assign irq_o        = irq_r;
   assign clear_done_o = clr_done_r;
endmodule

// >>> verif/hgt_timer_monitor.sv
// Port checker of the timer block.
module hgt_mon
   import hgt_pkg::*;
(
   input wire logic            clk_sys_i,
   input wire logic            rst_n_i,
   input wire hgt_bus_req_type bus_i,
   input wire logic            bus_hi_i,
   input wire logic            irq_clr_i,
   input wire logic [15:0]     rdata_o,
   input wire logic            irq_o,
   input wire logic            clear_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire rl = bus_i.rd && !bus_hi_i;
   wire rh = bus_i.rd && bus_hi_i;
   wire wl = bus_i.wr && !bus_hi_i && bus_i.addr == 8'h8C;
   AST_UNMAP: assert property (bus_i.rd && bus_i.addr == 8'h40 |=> rdata_o == 16'h0) else $error("bad");
   AST_CNT_HI: assert property (rh && bus_i.addr == 8'h90 |=> rdata_o == 16'h0) else $error("bad");
   AST_CFG_HI: assert property (rh && bus_i.addr == 8'h8C |=> rdata_o[12:0] == 13'h0) else $error("bad");
   AST_HOLD: assert property (!bus_i.rd |=> $stable(rdata_o)) else $error("bad");
   AST_IRQ: assert property (irq_o && !irq_clr_i |=> irq_o) else $error("bad");
   AST_DONE: assert property (clear_done_o |=> clear_done_o) else $error("bad");
   AST_WAIT: assert property (!clear_done_o |-> ##[1:22] clear_done_o) else $error("bad");
   AST_LOAD: assert property (wl ##3 rl && bus_i.addr == 8'h8C |=> rdata_o == $past(bus_i.wdata, 4))
      else $error("bad");
   AST_STEP: assert property (rl && bus_i.addr == 8'h9C ##5 rl && bus_i.addr == 8'h9C
      |=> rdata_o == $past(rdata_o, 5) + 16'h1) else $error("bad");
endmodule
bind hgt_timer hgt_mon mon (.*);

// >>> verif/hgt_host.sv
// Host processor model on the register port.
module hgt_host
   import hgt_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   output hgt_bus_req_type  bus_o,
   output logic             hi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      bus_o = '0;
      hi_o = 1'b0;
   end
   task automatic acc(logic w, logic [7:0] a, logic h, logic [15:0] d, output logic [15:0] q);
      @(negedge clk_i);
      bus_o = '{rd: !w, wr: w, addr: a, wdata: d};
      hi_o = h;
      @(negedge clk_i);
      bus_o = '0;
      @(negedge clk_i);
      q = rdata_i;
   endtask
endmodule

// >>> verif/host_general_timer_and_free_counter_tb_top.sv
// Self-checking bench of the timer block.
module host_general_timer_and_free_counter_tb_top import hgt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 0, rst_n_i = 0, irq_clr_i = 0, bus_hi_i, irq_o, clear_done_o;
   logic [15:0] rdata_o, v, w;
   logic [31:0] s = 32'hEC525737;
   hgt_bus_req_type bus_i;
   int bad_count = 0, checked = 0;
   initial forever #4 clk_sys_i = ~clk_sys_i;
   hgt_host host (.clk_i(clk_sys_i), .rdata_i(rdata_o), .bus_o(bus_i), .hi_o(bus_hi_i));
   hgt_timer uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .bus_hi_i(bus_hi_i),
      .irq_clr_i(irq_clr_i), .rdata_o(rdata_o), .irq_o(irq_o), .clear_done_o(clear_done_o));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         $display("mismatch %s exp %h got %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // The whole run takes near 1300 cycles; the limit leaves ample margin.
   localparam int LIMIT_CYC = 5000;
   function automatic logic [31:0] xorshift32(logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      y = y ^ (y << 5);
      return y;
   endfunction
   function automatic logic [15:0] cfg_hi_exp(logic run);
      return {2'h0, run, 13'h0000};
   endfunction
   initial
   begin
      repeat (LIMIT_CYC) @(posedge clk_sys_i);
      bad_count++;
      print_verdict();
   end
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i) rst_n_i = 1;
      chk("not_done", 16'h0000, clear_done_o);
      host.acc(0, 8'h8C, 0, 0, v);
      chk("cfg", 16'hFFFF, v);
      host.acc(0, 8'h90, 0, 0, v);
      chk("cnt", 16'hFFFF, v);
      host.acc(0, 8'h8C, 1, 0, v);
      chk("cfg_hi", cfg_hi_exp(0), v);
      host.acc(0, 8'h9C, 0, 0, v);
      repeat (2) @(negedge clk_sys_i);
      host.acc(0, 8'h9C, 0, 0, w);
      chk("free", v + 16'h0001, w);
      host.acc(0, 8'h9C, 1, 0, w);
      chk("free_hi", 16'h0000, w);
      for (int i = 0; i < 8; i++)
      begin
         s = xorshift32(s);
         host.acc(1, 8'h8C, 0, s[15:0], v);
         host.acc(0, 8'h8C, 0, 0, v);
         chk("load", s[15:0], v);
         host.acc(1, 8'h94, 0, ~s[15:0], v);
         host.acc(0, 8'h90, 0, 0, v);
         chk("count", s[15:0], v);
      end
      repeat (200) @(negedge clk_sys_i);
      host.acc(0, 8'h90, 0, 0, v);
      chk("halt", s[15:0], v);
      host.acc(1, 8'h8C, 0, 16'h0002, v);
      host.acc(1, 8'h8C, 1, 16'h2000, v);
      host.acc(0, 8'h8C, 1, 0, v);
      chk("run", cfg_hi_exp(1), v);
      repeat (100) @(negedge clk_sys_i);
      chk("early", 16'h0000, irq_o);
      for (int i = 0; i < 400 && irq_o !== 1'b1; i++)
         @(negedge clk_sys_i);
      chk("irq", 16'h0001, irq_o);
      irq_clr_i = 1;
      @(negedge clk_sys_i) irq_clr_i = 0;
      chk("clr", 16'h0000, irq_o);
      for (int i = 0; i < 400 && irq_o !== 1'b1; i++)
         @(negedge clk_sys_i);
      chk("reload", 16'h0001, irq_o);
      host.acc(1, 8'h8C, 1, 16'h0000, v);
      host.acc(0, 8'h8C, 0, 0, v);
      chk("preset", 16'hFFFF, v);
      host.acc(0, 8'h8C, 1, 0, v);
      chk("stop", cfg_hi_exp(0), v);
      host.acc(0, 8'h90, 0, 0, w);
      repeat (200) @(negedge clk_sys_i);
      host.acc(0, 8'h90, 0, 0, v);
      chk("frozen", w, v);
      host.acc(0, 8'h40, 0, 0, v);
      chk("unmap", 16'h0000, v);
      chk("done", 16'h0001, clear_done_o);
      print_verdict();
   end
endmodule
